// file: rmii_timing_pkg.sv
// Shared types and timing constants for the transceiver-side RMII block.
package rmii_timing_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int REF_PERIOD_NS = 20;
    localparam int BIT_TIME_NS = 10;
    localparam int TX_LAT_BITS = 11;
    localparam int CRS_ON_TENTH_BITS = 185;
    localparam int CRS_OFF_BITS = 27;
    localparam int DATA_LAT_BITS = 38;

    localparam int TX_CYC = (TX_LAT_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
    localparam int CRS_ON_CYC = (CRS_ON_TENTH_BITS * BIT_TIME_NS
                                 + 10 * CLK_PERIOD_NS - 1)
                                / (10 * CLK_PERIOD_NS);
    localparam int CRS_OFF_CYC = (CRS_OFF_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
    localparam int DATA_CYC = (DATA_LAT_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;

    localparam logic [1:0] EB_DEFAULT = 2'h1;
    localparam int EB_STEP_CYC = 4;
    localparam int DATA_LINE_LEN = DATA_CYC + 2 * EB_STEP_CYC;
    localparam int BUF_DEPTH = 2;

    typedef struct packed {
        logic en;
        logic [1:0] data;
    } tx_dibit_type;

    typedef struct packed {
        logic err;
        logic [1:0] data;
    } rx_dibit_type;

    typedef struct packed {
        logic valid;
        rx_dibit_type dibit;
    } rx_tap_type;

endpackage

// file: two_entry_buffer.sv
// Small valid/ready FIFO used on the receive dibit path.
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ff;
    logic [PW-1:0] rd_ff;
    logic [PW:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign in_ready = cnt_ff != (PW + 1)'(DEPTH);
    assign out_valid = cnt_ff != '0;
    assign out_data = mem_ff[rd_ff];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= next_ptr(wr_ff);
            end
            if (pop) begin
                rd_ff <= next_ptr(rd_ff);
            end
            cnt_ff <= cnt_ff + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end
endmodule

// file: rmii_phy_side.sv
// Transceiver-side reduced MII transmit and receive timing.
// Overview of operation
// [R01] - One 50 MHz reference clock for both directions.
// [R02] - MAC sets dibits for reference rising capture.
// [R03] - Transmit reaches line 11 bit times later.
// [R04] - Receive outputs change on reference rising edge.
// [R05] - Carrier valid rises 18.5 bits after start.
// [R06] - Carrier valid first falls 27 bits after end.
// [R07] - Receive data and error emerge after 38 bits.
// [R08] - Latencies hold at default elastic buffer setting.
// [R09] - Carrier valid rises without waiting for reference.
// [R10] - Carrier valid may toggle synchronously at frame end.
// [R11] - Auxiliary synchronous valid marks every delivered dibit.
// [R12] - One bit time equals 10 ns.
// [R13] - Tail alternates low odd, high even, until drained.
`timescale 1ns/1ps
module rmii_phy_side
    import rmii_timing_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Reference clock from the board.
    input wire logic ref_clock_in,
    // Transmit dibits from the MAC.
    input wire logic tx_en,
    input wire logic [1:0] txd,
    // Receive dibits to the MAC.
    output logic crs_dv,
    output logic [1:0] rxd,
    output logic rx_er,
    output logic aux_receive_valid,
    // Line transmit side.
    output logic line_tx_en,
    output logic [1:0] line_tx_data,
    // Line receive side from the symbol decoder.
    input wire logic rx_line_valid,
    input wire logic [1:0] rx_line_data,
    input wire logic rx_line_err,
    input wire logic rx_sos,
    input wire logic rx_eos,
    // Configuration and status.
    input wire logic [1:0] eb_setting,
    output logic rx_overrun
);
    logic ref_meta_ff;
    logic ref_s_ff;
    logic ref_prev_ff;
    tx_dibit_type tx_meta_ff;
    tx_dibit_type tx_s_ff;
    logic [1:0] eb_meta_ff;
    logic [1:0] eb_s_ff;
    tx_dibit_type tx_cap_ff;
    tx_dibit_type tx_line_ff [TX_CYC - 2];
    tx_dibit_type line_tx_ff;
    logic [CRS_ON_CYC-2:0] sos_line_ff;
    logic [CRS_OFF_CYC-2:0] eos_line_ff;
    rx_tap_type data_line_ff [DATA_LINE_LEN];
    logic crs_dv_ff;
    logic tail_ff;
    logic phase_ff;
    rx_dibit_type rx_out_ff;
    logic aux_valid_ff;
    logic overrun_ff;
    logic line_pending;

    function automatic int eb_tap(input logic [1:0] eb);
        eb_tap = DATA_CYC - 1 + (int'(eb) - 1) * EB_STEP_CYC;
    endfunction

    wire ref_rise = ref_s_ff && !ref_prev_ff; // [R01]
    wire sos_hit = sos_line_ff[CRS_ON_CYC-2];
    wire eos_hit = eos_line_ff[CRS_OFF_CYC-2];
    wire rx_tap_type data_tap = data_line_ff[eb_tap(eb_s_ff)]; // [R08]
    wire buf_in_valid = data_tap.valid;
    wire buf_in_ready;
    wire buf_out_valid;
    wire [$bits(rx_dibit_type)-1:0] buf_out_bits;
    wire rx_dibit_type buf_out = rx_dibit_type'(buf_out_bits);

    // Dibits still in the delay line keep the carrier tail open.
    always_comb begin
        line_pending = 1'b0;
        for (int i = 0; i < DATA_LINE_LEN; i++) begin
            if (i <= eb_tap(eb_s_ff) && data_line_ff[i].valid) begin
                line_pending = 1'b1; // [R13]
            end
        end
    end

    two_entry_buffer #(
        .WIDTH($bits(rx_dibit_type)),
        .DEPTH(BUF_DEPTH)
    ) rx_buffer (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(data_tap.dibit),
        .out_valid(buf_out_valid),
        .out_ready(ref_rise),
        .out_data(buf_out_bits)
    );

    assign crs_dv = crs_dv_ff;
    assign rxd = rx_out_ff.data;
    assign rx_er = rx_out_ff.err;
    assign aux_receive_valid = aux_valid_ff;
    assign line_tx_en = line_tx_ff.en;
    assign line_tx_data = line_tx_ff.data;
    assign rx_overrun = overrun_ff;

    // Pin synchronisers and reference edge finder.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ref_meta_ff <= 1'b0;
            ref_s_ff <= 1'b0;
            ref_prev_ff <= 1'b0;
            tx_meta_ff <= '0;
            tx_s_ff <= '0;
            eb_meta_ff <= EB_DEFAULT;
            eb_s_ff <= EB_DEFAULT;
        end else begin
            ref_meta_ff <= ref_clock_in;
            ref_s_ff <= ref_meta_ff;
            ref_prev_ff <= ref_s_ff;
            tx_meta_ff <= '{en: tx_en, data: txd};
            tx_s_ff <= tx_meta_ff;
            eb_meta_ff <= eb_setting;
            eb_s_ff <= eb_meta_ff;
        end
    end

    // Transmit capture and fixed line latency.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_cap_ff <= '0;
            line_tx_ff <= '0;
            for (int i = 0; i < TX_CYC - 2; i++) begin
                tx_line_ff[i] <= '0;
            end
        end else begin
            if (ref_rise) begin
                tx_cap_ff <= tx_s_ff; // [R02]
            end
            tx_line_ff[0] <= tx_cap_ff;
            for (int i = 1; i < TX_CYC - 2; i++) begin
                tx_line_ff[i] <= tx_line_ff[i-1];
            end
            line_tx_ff <= tx_line_ff[TX_CYC-3]; // [R03] [R12]
        end
    end

    // Receive delay lines for stream markers and dibits.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sos_line_ff <= '0;
            eos_line_ff <= '0;
            for (int i = 0; i < DATA_LINE_LEN; i++) begin
                data_line_ff[i] <= '0;
            end
        end else begin
            sos_line_ff <= {sos_line_ff[CRS_ON_CYC-3:0], rx_sos}; // [R05]
            eos_line_ff <= {eos_line_ff[CRS_OFF_CYC-3:0], rx_eos}; // [R06]
            data_line_ff[0] <= '{valid: rx_line_valid,
                                 dibit: '{err: rx_line_err,
                                          data: rx_line_data}}; // [R07]
            for (int i = 1; i < DATA_LINE_LEN; i++) begin
                data_line_ff[i] <= data_line_ff[i-1];
            end
        end
    end

    // Carrier valid: immediate rise, synchronous toggle while draining.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            crs_dv_ff <= 1'b0;
            tail_ff <= 1'b0;
            phase_ff <= 1'b0;
        end else if (sos_hit) begin
            crs_dv_ff <= 1'b1; // [R09] [R05]
            tail_ff <= 1'b0;
        end else if (eos_hit) begin
            crs_dv_ff <= 1'b0; // [R06]
            tail_ff <= 1'b1;
            phase_ff <= 1'b0;
        end else if (tail_ff && ref_rise) begin
            if (buf_out_valid) begin
                crs_dv_ff <= phase_ff; // [R10] [R13]
                phase_ff <= !phase_ff;
            end else if (!line_pending) begin
                crs_dv_ff <= 1'b0; // [R13]
                tail_ff <= 1'b0;
            end
        end
    end

    // Receive outputs update only on reference rising edges; the overrun flag updates every cycle.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_out_ff <= '0;
            aux_valid_ff <= 1'b0;
            overrun_ff <= 1'b0;
        end else begin
            if (ref_rise) begin
                rx_out_ff <= buf_out_valid ? buf_out : '0; // [R04] [R07]
                aux_valid_ff <= buf_out_valid; // [R11]
            end
            overrun_ff <= buf_in_valid && !buf_in_ready;
        end
    end

    AST_REF_EDGE: assert property (@(posedge clock) // [R01]
        disable iff (sys_rst)
        ref_rise |=> !ref_rise)
        else $error("Reference rise seen on two adjacent cycles.");

    AST_TX_LAT: assert property (@(posedge clock) // [R03]
        disable iff (sys_rst)
        ref_rise |-> ##11 (line_tx_en == $past(tx_s_ff.en, 11)
                           && line_tx_data == $past(tx_s_ff.data, 11)))
        else $error("Transmit dibit not on line 11 cycles after capture.");

    AST_RX_HOLD: assert property (@(posedge clock) // [R04]
        disable iff (sys_rst)
        !$past(ref_rise) |-> ($stable(rxd) && $stable(rx_er)
                              && $stable(aux_receive_valid)))
        else $error("Receive output changed away from a reference edge.");

    AST_CRS_ON: assert property (@(posedge clock) // [R05]
        disable iff (sys_rst)
        (rx_sos && !$past(rx_eos, 8)) |-> ##19 crs_dv)
        else $error("Carrier valid not high 19 cycles after stream start.");

    AST_CRS_OFF: assert property (@(posedge clock) // [R06]
        disable iff (sys_rst)
        (rx_eos ##8 !rx_sos) |-> ##19 (!crs_dv && tail_ff))
        else $error("Carrier valid not low 27 cycles after stream end.");

    AST_DATA_LAT: assert property (@(posedge clock) // [R07]
        disable iff (sys_rst)
        (rx_line_valid && eb_s_ff == EB_DEFAULT) |-> ##38 buf_in_valid)
        else $error("Receive dibit not buffered 38 cycles after arrival.");

    AST_AUX_VALID: assert property (@(posedge clock) // [R11]
        disable iff (sys_rst)
        ref_rise |=> (aux_receive_valid == $past(buf_out_valid)))
        else $error("Auxiliary valid does not follow delivered dibit.");

    AST_TOGGLE: assert property (@(posedge clock) // [R13]
        disable iff (sys_rst)
        (ref_rise && tail_ff && buf_out_valid && !sos_hit && !eos_hit)
        |=> (crs_dv == $past(phase_ff) && phase_ff != $past(phase_ff)))
        else $error("Carrier valid did not alternate while draining.");

    AST_TAIL_END: assert property (@(posedge clock) // [R13]
        disable iff (sys_rst)
        (ref_rise && tail_ff && !buf_out_valid && !line_pending
         && !sos_hit && !eos_hit)
        |=> (!crs_dv && !tail_ff))
        else $error("Carrier valid not low once the buffer drained.");
endmodule

// file: mac_model.sv
// Behavioural MAC facing the block across the reduced MII.
`timescale 1ns/1ps
module mac_model (
    // Clocks.
    input wire logic clock,
    input wire logic ref_clock_in,
    // Transmit toward the block.
    output logic tx_en = 1'b0,
    output logic [1:0] txd = 2'h0,
    // Receive from the block.
    input wire logic aux_receive_valid,
    input wire logic rx_er,
    input wire logic [1:0] rxd
);
    logic ref_q = 1'b0;
    logic [1:0] tx_q[$];
    logic [2:0] rx_q[$];

    // Changes just after each reference rise and holds for the period.
    always @(posedge clock) begin
        ref_q <= ref_clock_in;
        if (ref_clock_in && !ref_q) begin
            if (tx_q.size() > 0) begin
                tx_en <= 1'b1;
                txd <= tx_q.pop_front();
            end else begin
                tx_en <= 1'b0;
                txd <= ~txd;
            end
            if (aux_receive_valid === 1'b1) begin
                rx_q.push_back({rx_er, rxd});
            end
        end
    end
endmodule

// file: testbench.sv
// Self-checking bench for the transceiver-side reduced MII block.
`timescale 1ns/1ps
module testbench
    import rmii_timing_pkg::*;
;
    logic clock, sys_rst, ref_clock_in, tx_en, crs_dv, rx_er, aux_valid;
    logic line_tx_en, rx_line_valid, rx_line_err, rx_sos, rx_eos, ovr;
    logic [1:0] txd, rxd, line_tx_data, rx_line_data, eb_setting;
    int mismatches = 0;
    int checks = 0;

    rmii_phy_side uut (.clock(clock), .sys_rst(sys_rst),
        .ref_clock_in(ref_clock_in), .tx_en(tx_en), .txd(txd),
        .crs_dv(crs_dv), .rxd(rxd), .rx_er(rx_er),
        .aux_receive_valid(aux_valid), .line_tx_en(line_tx_en),
        .line_tx_data(line_tx_data), .rx_line_valid(rx_line_valid),
        .rx_line_data(rx_line_data), .rx_line_err(rx_line_err),
        .rx_sos(rx_sos), .rx_eos(rx_eos), .eb_setting(eb_setting),
        .rx_overrun(ovr));
    mac_model mac (.clock(clock), .ref_clock_in(ref_clock_in),
        .tx_en(tx_en), .txd(txd), .aux_receive_valid(aux_valid),
        .rx_er(rx_er), .rxd(rxd));

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_level(ref logic s, input logic v, input int lim,
                              output int cyc);
        cyc = 0;
        while (s !== v && cyc < lim) begin
            @(posedge clock);
            #1;
            cyc++;
        end
    endtask

    task automatic send(input logic s, e, v, input logic [2:0] d);
        @(posedge clock);
        rx_sos <= s;
        rx_eos <= e;
        rx_line_valid <= v;
        {rx_line_err, rx_line_data} <= d;
        @(posedge clock);
        rx_sos <= 1'b0;
        rx_eos <= 1'b0;
        rx_line_valid <= 1'b0;
    endtask

    task automatic t_tx;
        logic [1:0] exp[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
        logic [1:0] prev;
        int cyc;
        foreach (exp[i]) mac.tx_q.push_back(exp[i]);
        wait_level(line_tx_en, 1'b1, 60, cyc);
        check("line_tx_data", 8'(line_tx_data), 8'(exp[0]));
        for (int i = 1; i < 4; i++) begin
            prev = line_tx_data;
            cyc = 0;
            while (line_tx_data === prev && cyc < 20) begin
                @(posedge clock);
                #1;
                cyc++;
            end
            check("line_tx_data", 8'(line_tx_data), 8'(exp[i]));
        end
        wait_level(line_tx_en, 1'b0, 20, cyc);
        check("line_tx_en_off", 8'(cyc < 20), 8'h1);
        $display("test transmit done");
    endtask

    task automatic t_rx;
        logic [2:0] sent[4] = '{3'h3, 3'h5, 3'h2, 3'h4};
        int cyc;
        mac.rx_q.delete();
        send(1'b1, 1'b0, 1'b0, 3'h0);
        wait_level(crs_dv, 1'b1, 40, cyc);
        // The count starts at the taking edge, one after the pulse is driven.
        check("crs_on_cycles", 8'(cyc), 8'(CRS_ON_CYC - 1));
        foreach (sent[i]) begin
            repeat (11) @(posedge clock);
            send(1'b0, 1'b0, 1'b1, sent[i]);
        end
        send(1'b0, 1'b1, 1'b0, 3'h0);
        wait_level(crs_dv, 1'b0, 40, cyc);
        check("crs_off_cycles", 8'(cyc), 8'(CRS_OFF_CYC - 1));
        repeat (150) @(posedge clock);
        check("crs_tail_end", 8'(crs_dv), 8'h0);
        check("rx_count", 8'(mac.rx_q.size()), 8'h4);
        foreach (sent[i]) begin
            check("rx_dibit", 8'(mac.rx_q[i]), 8'(sent[i]));
        end
        $display("test receive done");
    endtask

    task automatic t_eb;
        int cyc, lo;
        for (int e = 0; e < 4; e++) begin
            eb_setting <= 2'(e);
            repeat (5) @(posedge clock);
            send(1'b1, 1'b0, 1'b0, 3'h0);
            send(1'b0, 1'b0, 1'b1, 3'h1);
            lo = DATA_CYC + (e - 1) * EB_STEP_CYC + 1;
            wait_level(aux_valid, 1'b1, 80, cyc);
            check("data_lat", 8'(cyc >= lo && cyc <= lo + 15), 8'h1);
            check("rxd", 8'(rxd), 8'h1);
            send(1'b0, 1'b1, 1'b0, 3'h0);
            repeat (100) @(posedge clock);
        end
        eb_setting <= EB_DEFAULT;
        $display("test elastic settings done");
    endtask

    task automatic t_overrun;
        int cyc;
        send(1'b1, 1'b0, 1'b0, 3'h0);
        for (int i = 0; i < 5; i++) send(1'b0, 1'b0, 1'b1, 3'(i));
        wait_level(ovr, 1'b1, 60, cyc);
        check("overrun_seen", 8'(cyc < 60), 8'h1);
        send(1'b0, 1'b1, 1'b0, 3'h0);
        repeat (120) @(posedge clock);
        check("aux_idle", 8'(aux_valid), 8'h0);
        $display("test overrun done");
    endtask

    // System clock at 100 MHz; one cycle is one bit time.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Reference clock, unrelated in phase to the system clock.
    initial begin
        ref_clock_in = 1'b0;
        forever #62.5 ref_clock_in = ~ref_clock_in;
    end

    initial begin
        sys_rst = 1'b1;
        rx_sos = 1'b0;
        rx_eos = 1'b0;
        rx_line_valid = 1'b0;
        rx_line_err = 1'b0;
        rx_line_data = 2'h0;
        eb_setting = EB_DEFAULT;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1;
        check("crs_dv_reset", 8'(crs_dv), 8'h0);
        check("aux_reset", 8'(aux_valid), 8'h0);
        t_tx();
        t_rx();
        t_eb();
        t_overrun();
        close_out();
    end

    initial begin
        #200000;
        mismatches++;
        $display("watchdog expired");
        close_out();
    end
endmodule
